// file: rtl/asct_defines.svh
`ifndef ASCT_DEFINES_SVH
`define ASCT_DEFINES_SVH

// register byte offsets
`define ASCT_OFF_CTRL      12'h000
`define ASCT_OFF_BAUD      12'h004
`define ASCT_OFF_CDT       12'h008
`define ASCT_OFF_TXDATA    12'h00C
`define ASCT_OFF_RXDATA    12'h010
`define ASCT_OFF_STATUS    12'h014

// control field positions
`define ASCT_CTRL_MODE_LO  0
`define ASCT_CTRL_MODE_HI  1
`define ASCT_CTRL_TWOWIRE  2
`define ASCT_CTRL_DBITS    3
`define ASCT_CTRL_PAREN    4
`define ASCT_CTRL_PARODD   5
`define ASCT_CTRL_STOP2    6
`define ASCT_CTRL_XONXOFF  7
`define ASCT_CTRL_CTSEN    8

// status bit positions
`define ASCT_ST_TXBUSY     0
`define ASCT_ST_RXBUSY     1
`define ASCT_ST_RXVALID    2
`define ASCT_ST_CDTERR     3
`define ASCT_ST_FRMERR     4
`define ASCT_ST_XOFF       5
`define ASCT_ST_TXFULL     6

// reset values
`define ASCT_CTRL_RST      9'h000
`define ASCT_BAUD_RST      16'h0104
`define ASCT_CDT_RST       16'h0020

// flow control characters
`define ASCT_CHR_XON       8'h11
`define ASCT_CHR_XOFF      8'h13

`endif

// file: rtl/asct_pkg.sv
package asct_pkg;

    typedef enum logic [1:0] {
        ASCT_MODE_HALF    = 2'b00,
        ASCT_MODE_FULL    = 2'b01,
        ASCT_MODE_PRINTER = 2'b10,
        ASCT_MODE_RSVD    = 2'b11
    } asct_mode_e;

    typedef struct packed {
        logic       ctsen;
        logic       xonxoff;
        logic       stop2;
        logic       parodd;
        logic       paren;
        logic       dbits7;
        logic       twowire;
        asct_mode_e mode;
    } asct_cfg_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       frm_err;
    } asct_rxchar_s;

endpackage : asct_pkg

// file: rtl/asct_tx.sv
`timescale 1ns/1ps
`include "asct_defines.svh"

module asct_tx
    import asct_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire asct_cfg_s   cfg,
    input  wire logic [15:0] baud_div,
    input  wire logic        start,
    input  wire logic [7:0]  data,
    output logic             busy,
    output logic             txd
);

    typedef enum logic [1:0] {
        ASCT_TX_IDLE = 2'b00,
        ASCT_TX_SHIFT = 2'b01
    } asct_tx_state_e;

    typedef struct packed {
        asct_tx_state_e st;
        logic [15:0]    cnt;
        logic [3:0]     bits;
        logic [10:0]    sh;
        logic           txd;
    } asct_tx_s;

    asct_tx_s s_r, s_nxt;
    logic     par;
    logic [3:0] nbits;

    always_comb begin
        s_nxt = s_r;
        par   = (cfg.dbits7 ? ^data[6:0] : ^data) ^ cfg.parodd;
        nbits = 4'd2 + (cfg.dbits7 ? 4'd7 : 4'd8) + {3'd0, cfg.paren} + {3'd0, cfg.stop2};
        unique case (s_r.st)
            ASCT_TX_IDLE: begin
                s_nxt.txd = 1'b1;
                if (start) begin
                    // start bit first, lsb first, then parity and stop
                    s_nxt.sh  = cfg.dbits7 ? {2'b11, cfg.paren ? par : 1'b1, data[6:0], 1'b0}
                                           : {1'b1, cfg.paren ? par : 1'b1, data, 1'b0}; // RULE1 RULE7 RULE12
                    s_nxt.bits = nbits;
                    s_nxt.cnt  = baud_div;
                    s_nxt.st   = ASCT_TX_SHIFT;
                    s_nxt.txd  = 1'b0; // RULE7
                end
            end
            ASCT_TX_SHIFT: begin
                if (s_r.cnt <= 16'd1) begin
                    s_nxt.cnt  = baud_div;
                    s_nxt.sh   = {1'b1, s_r.sh[10:1]};
                    s_nxt.bits = s_r.bits - 4'd1;
                    s_nxt.txd  = s_r.sh[1];
                    if (s_r.bits == 4'd1) begin
                        s_nxt.st  = ASCT_TX_IDLE; // RULE10
                        s_nxt.txd = 1'b1;
                    end
                end else begin
                    s_nxt.cnt = s_r.cnt - 16'd1;
                end
            end
            default: s_nxt.st = ASCT_TX_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '{st: ASCT_TX_IDLE, cnt: 16'h0000, bits: 4'h0, sh: 11'h7FF, txd: 1'b1};
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign busy = (s_r.st != ASCT_TX_IDLE);
    assign txd  = s_r.txd;

endmodule : asct_tx

// file: rtl/asct_rx.sv
`timescale 1ns/1ps
`include "asct_defines.svh"

module asct_rx
    import asct_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire asct_cfg_s   cfg,
    input  wire logic [15:0] baud_div,
    input  wire logic        rxd_s,
    output asct_rxchar_s     rxc,
    output logic             busy
);

    typedef enum logic [1:0] {
        ASCT_RX_IDLE  = 2'b00,
        ASCT_RX_START = 2'b01,
        ASCT_RX_DATA  = 2'b10
    } asct_rx_state_e;

    typedef struct packed {
        asct_rx_state_e st;
        logic [15:0]    cnt;
        logic [3:0]     bits;
        logic [9:0]     sh;
        asct_rxchar_s   out;
    } asct_rx_s;

    asct_rx_s   s_r, s_nxt;
    logic [3:0] nbits;
    logic [7:0] d;
    logic       perr;

    always_comb begin
        s_nxt = s_r;
        s_nxt.out.valid = 1'b0;
        nbits = (cfg.dbits7 ? 4'd7 : 4'd8) + {3'd0, cfg.paren} + 4'd1;
        // with parity the last data bit sits one place below the parity bit
        d     = cfg.paren ? (cfg.dbits7 ? {1'b0, s_r.sh[8:2]} : s_r.sh[8:1])
                          : (cfg.dbits7 ? {1'b0, s_r.sh[9:3]} : s_r.sh[9:2]); // RULE1
        perr  = 1'b0;
        unique case (s_r.st)
            ASCT_RX_IDLE: begin
                // every character resynchronises on its own falling edge
                if (!rxd_s) begin
                    s_nxt.st  = ASCT_RX_START;
                    s_nxt.cnt = {1'b0, baud_div[15:1]}; // RULE8 RULE9
                end
            end
            ASCT_RX_START: begin
                if (s_r.cnt <= 16'd1) begin
                    s_nxt.cnt  = baud_div;
                    s_nxt.bits = nbits;
                    s_nxt.st   = rxd_s ? ASCT_RX_IDLE : ASCT_RX_DATA; // RULE8
                end else begin
                    s_nxt.cnt = s_r.cnt - 16'd1;
                end
            end
            ASCT_RX_DATA: begin
                if (s_r.cnt <= 16'd1) begin
                    s_nxt.cnt  = baud_div;
                    s_nxt.sh   = {rxd_s, s_r.sh[9:1]}; // RULE1
                    s_nxt.bits = s_r.bits - 4'd1;
                    if (s_r.bits == 4'd1) begin
                        if (cfg.paren) begin
                            perr = cfg.dbits7 ? (^s_r.sh[9:2] ^ cfg.parodd) : (^s_r.sh[9:1] ^ cfg.parodd); // RULE14
                        end
                        s_nxt.out.data    = d;
                        s_nxt.out.frm_err = perr | ~rxd_s; // RULE10 RULE14
                        s_nxt.out.valid   = 1'b1;
                        s_nxt.st          = ASCT_RX_IDLE; // RULE9
                    end
                end else begin
                    s_nxt.cnt = s_r.cnt - 16'd1;
                end
            end
            default: s_nxt.st = ASCT_RX_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '{st: ASCT_RX_IDLE, cnt: 16'h0000, bits: 4'h0, sh: 10'h000,
                     out: '{valid: 1'b0, data: 8'h00, frm_err: 1'b0}};
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign rxc  = s_r.out;
    assign busy = (s_r.st != ASCT_RX_IDLE);

endmodule : asct_rx

// file: rtl/asct_top.sv
// Operation
// RULE1: bits shifted and reassembled lsb first
// RULE2: printer mode receives only XON/XOFF
// RULE3: half duplex alternates send and receive
// RULE4: flow characters pass during half-duplex traffic
// RULE5: full duplex runs both directions together
// RULE6: two-wire setting forbids full duplex
// RULE7: start bit precedes every character
// RULE8: receiver times bits from start edge
// RULE9: receiver resynchronises on every character
// RULE10: stop bit closes each character
// RULE11: both ends share configured line settings
// RULE12: ten-bit frame with selectable formats; the transmitter sends 9 to 12 bits depending on dbits7, paren and stop2
// RULE13: character delay time limits gaps
// RULE14: parity checked when enabled
// RULE15: printer busy on cts holds output
// RULE16: flags for delay timeout and errors
// RULE17: xoff stops, xon resumes transmit
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "asct_defines.svh"

module asct_top
    import asct_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rxd,
    input  wire logic        cts_n,
    output logic             txd,
    output logic             tx_oe
);

    // ===========================================================
    // state
    // ===========================================================
    typedef struct packed {
        asct_cfg_s    cfg;
        logic [15:0]  baud;
        logic [15:0]  cdt;
        logic [7:0]   txbuf;
        logic         txfull;
        logic         txstart;
        logic [7:0]   rxdata;
        logic         rxvalid;
        logic         cdt_err;
        logic         frm_err;
        logic         xoff;
        logic         in_frame;
        logic [31:0]  gap_cnt;
        logic [31:0]  prdata;
        logic         pready;
        logic         pslverr;
        logic [1:0]   rxd_sync;
        logic [1:0]   cts_sync;
        logic         txd;
        logic         tx_oe;
    } asct_top_s;

    asct_top_s    s_r, s_nxt;
    logic         tx_busy, tx_line, rx_busy;
    asct_rxchar_s rxc;
    logic         wr, rd, flowchr, hdx_hold, cts_hold, tx_go, rx_store;
    logic [31:0]  gap_limit;

    asct_tx u_tx (
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (ce),
        .cfg      (s_r.cfg),
        .baud_div (s_r.baud),
        .start    (tx_go),
        .data     (s_r.txbuf),
        .busy     (tx_busy),
        .txd      (tx_line)
    );

    asct_rx u_rx (
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (ce),
        .cfg      (s_r.cfg),
        .baud_div (s_r.baud),
        .rxd_s    (s_r.rxd_sync[1]),
        .rxc      (rxc),
        .busy     (rx_busy)
    );

    // ===========================================================
    // transmit gating
    // ===========================================================
    always_comb begin
        flowchr   = (s_r.txbuf == `ASCT_CHR_XON) || (s_r.txbuf == `ASCT_CHR_XOFF);
        // half duplex: no user data out while a character comes in
        hdx_hold  = (s_r.cfg.mode != ASCT_MODE_FULL) && rx_busy && !flowchr; // RULE3 RULE4 RULE5
        cts_hold  = (s_r.cfg.mode == ASCT_MODE_PRINTER) && s_r.cfg.ctsen && s_r.cts_sync[1]; // RULE15
        tx_go     = s_r.txfull && !tx_busy && !s_r.txstart && !hdx_hold && !cts_hold
                    && !(s_r.xoff && s_r.cfg.xonxoff && !flowchr); // RULE17
        gap_limit = {16'h0000, s_r.cdt} * {16'h0000, s_r.baud};
        // user character kept for software except in printer mode or in half duplex with txfull set; with xonxoff, flow characters only steer the transmitter
        rx_store  = rxc.valid && (s_r.cfg.mode != ASCT_MODE_PRINTER)
                    && !(s_r.cfg.mode == ASCT_MODE_HALF && s_r.txfull)
                    && !(s_r.cfg.xonxoff && (rxc.data == `ASCT_CHR_XON || rxc.data == `ASCT_CHR_XOFF));
    end

    // ===========================================================
    // next state
    // ===========================================================
    always_comb begin
        s_nxt          = s_r;
        wr             = psel && penable && pwrite;
        rd             = psel && penable && !pwrite;
        s_nxt.rxd_sync = {s_r.rxd_sync[0], rxd};
        s_nxt.cts_sync = {s_r.cts_sync[0], ~cts_n};
        s_nxt.txd      = tx_line;
        s_nxt.tx_oe    = tx_busy || !s_r.cfg.twowire || (s_r.cfg.mode == ASCT_MODE_FULL);
        s_nxt.txstart  = 1'b0;
        s_nxt.pready   = 1'b0;
        s_nxt.pslverr  = 1'b0;

        if (tx_go) begin
            s_nxt.txfull  = 1'b0;
            s_nxt.txstart = 1'b1;
        end

        // character delay supervision within a frame
        if (rx_busy || rxc.valid) begin
            s_nxt.gap_cnt = 32'h0000_0000;
        end else if (s_r.in_frame) begin
            if (s_r.gap_cnt >= gap_limit) begin
                s_nxt.in_frame = 1'b0;
                s_nxt.cdt_err  = 1'b1; // RULE13 RULE16
            end else begin
                s_nxt.gap_cnt = s_r.gap_cnt + 32'h0000_0001;
            end
        end

        if (rxc.valid) begin
            s_nxt.in_frame = 1'b1;
            if (s_r.cfg.xonxoff && rxc.data == `ASCT_CHR_XOFF) begin
                s_nxt.xoff = 1'b1; // RULE17
            end else if (s_r.cfg.xonxoff && rxc.data == `ASCT_CHR_XON) begin
                s_nxt.xoff = 1'b0; // RULE17
            end
        end
        if (rx_store) begin // RULE2 RULE3 RULE4
            s_nxt.rxdata  = rxc.data;
            s_nxt.rxvalid = 1'b1;
        end
        if (rxc.valid && rxc.frm_err && s_r.cfg.mode != ASCT_MODE_PRINTER) begin
            s_nxt.frm_err = 1'b1; // RULE16
        end

        if (psel && penable && !s_r.pready) begin
            s_nxt.pready = 1'b1;
            if (wr) begin
                unique case (paddr)
                    `ASCT_OFF_CTRL: begin
                        s_nxt.cfg = asct_cfg_s'(pwdata[8:0]);
                        if (pwdata[`ASCT_CTRL_TWOWIRE] && pwdata[1:0] == 2'b01) begin
                            s_nxt.cfg.mode = ASCT_MODE_HALF; // RULE6
                            s_nxt.pslverr  = 1'b1;
                        end
                        if (pwdata[1:0] == 2'b11) begin
                            s_nxt.cfg.mode = ASCT_MODE_HALF;
                        end
                    end
                    `ASCT_OFF_BAUD:   s_nxt.baud = pwdata[15:0]; // RULE11
                    `ASCT_OFF_CDT:    s_nxt.cdt  = pwdata[15:0];
                    `ASCT_OFF_TXDATA: begin
                        if (!s_r.txfull) begin
                            s_nxt.txbuf  = pwdata[7:0];
                            s_nxt.txfull = 1'b1;
                        end else begin
                            s_nxt.pslverr = 1'b1;
                        end
                    end
                    `ASCT_OFF_STATUS: begin
                        // write one to clear; hardware set wins
                        if (pwdata[`ASCT_ST_CDTERR] && !s_nxt.cdt_err) s_nxt.cdt_err = 1'b0;
                        if (pwdata[`ASCT_ST_CDTERR] && s_r.cdt_err && s_nxt.cdt_err == s_r.cdt_err
                            && !(s_r.in_frame && s_r.gap_cnt >= gap_limit)) s_nxt.cdt_err = 1'b0;
                        if (pwdata[`ASCT_ST_FRMERR] && !(rxc.valid && rxc.frm_err)) s_nxt.frm_err = 1'b0;
                    end
                    default: s_nxt.pslverr = 1'b1;
                endcase
            end else begin
                unique case (paddr)
                    `ASCT_OFF_CTRL:   s_nxt.prdata = {23'h0, s_r.cfg};
                    `ASCT_OFF_BAUD:   s_nxt.prdata = {16'h0000, s_r.baud};
                    `ASCT_OFF_CDT:    s_nxt.prdata = {16'h0000, s_r.cdt};
                    `ASCT_OFF_TXDATA: s_nxt.prdata = {24'h00_0000, s_r.txbuf};
                    `ASCT_OFF_RXDATA: begin
                        s_nxt.prdata = {24'h00_0000, s_r.rxdata};
                        if (!rx_store) s_nxt.rxvalid = 1'b0;
                    end
                    `ASCT_OFF_STATUS: s_nxt.prdata = {25'h000_0000, s_r.txfull, s_r.xoff, s_r.frm_err,
                                                      s_r.cdt_err, s_r.rxvalid, rx_busy, tx_busy};
                    default: begin
                        s_nxt.prdata  = 32'h0000_0000;
                        s_nxt.pslverr = 1'b1;
                    end
                endcase
            end
        end
    end

    // ===========================================================
    // registers
    // ===========================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r          <= '0;
            s_r.cfg      <= asct_cfg_s'(`ASCT_CTRL_RST);
            s_r.baud     <= `ASCT_BAUD_RST;
            s_r.cdt      <= `ASCT_CDT_RST;
            s_r.rxd_sync <= 2'b11;
            s_r.cts_sync <= 2'b00;
            s_r.txd      <= 1'b1;
            s_r.tx_oe    <= 1'b1;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign prdata  = s_r.prdata;
    assign pready  = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign txd     = s_r.txd;
    assign tx_oe   = s_r.tx_oe;

    // ===========================================================
    // checks
    // ===========================================================
    property p_no_fdx_twowire;
        @(posedge pclk) disable iff (!presetn)
        s_r.cfg.twowire |-> s_r.cfg.mode != ASCT_MODE_FULL;
    endproperty
    a_no_fdx_twowire: assert property (p_no_fdx_twowire) else $error("full duplex on two-wire"); // RULE6

    property p_start_low;
        @(posedge pclk) disable iff (!presetn)
        ce && $rose(tx_busy) |=> ##1 !txd;
    endproperty
    a_start_low: assert property (p_start_low) else $error("no start bit"); // RULE7

    property p_printer_drop;
        @(posedge pclk) disable iff (!presetn)
        ce && rxc.valid && s_r.cfg.mode == ASCT_MODE_PRINTER && !s_r.rxvalid |=> !s_r.rxvalid;
    endproperty
    a_printer_drop: assert property (p_printer_drop) else $error("printer mode stored a char"); // RULE2

    property p_cts_hold;
        @(posedge pclk) disable iff (!presetn)
        cts_hold |-> !tx_go;
    endproperty
    a_cts_hold: assert property (p_cts_hold) else $error("sent while printer busy"); // RULE15

    property p_xoff_hold;
        @(posedge pclk) disable iff (!presetn)
        s_r.xoff && s_r.cfg.xonxoff && !flowchr |-> !tx_go;
    endproperty
    a_xoff_hold: assert property (p_xoff_hold) else $error("sent after xoff"); // RULE17

    property p_hdx;
        @(posedge pclk) disable iff (!presetn)
        s_r.cfg.mode == ASCT_MODE_HALF && rx_busy && !flowchr |-> !tx_go;
    endproperty
    a_hdx: assert property (p_hdx) else $error("half duplex collision"); // RULE3

    property p_frm_flag;
        @(posedge pclk) disable iff (!presetn)
        ce && rxc.valid && rxc.frm_err && s_r.cfg.mode != ASCT_MODE_PRINTER
        && !s_r.txfull |=> s_r.frm_err;
    endproperty
    a_frm_flag: assert property (p_frm_flag) else $error("error flag missed"); // RULE16

    property p_pready;
        @(posedge pclk) disable iff (!presetn)
        ce && psel && penable && !pready |=> pready;
    endproperty
    a_pready: assert property (p_pready) else $error("apb no answer"); // RULE11

    c_tx:  cover property (@(posedge pclk) disable iff (!presetn) tx_go);
    c_rx:  cover property (@(posedge pclk) disable iff (!presetn) rxc.valid);
    c_cdt: cover property (@(posedge pclk) disable iff (!presetn) $rose(s_r.cdt_err));

endmodule : asct_top

// file: dv/asct_partner.sv
`timescale 1ns/1ps

module asct_partner (
    input  wire logic pclk,
    input  wire logic txd,
    output logic      rxd
);
    int         bit_cyc = 16;
    logic [7:0] got_q[$];
    logic [7:0] sh;

    initial rxd = 1'b1;

    // ==========================================
    // receive side: sample mid bit, lsb first
    always begin
        @(negedge txd);
        repeat (bit_cyc / 2) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_cyc) @(posedge pclk);
            sh[i] = txd;
        end
        repeat (bit_cyc) @(posedge pclk);
        if (txd === 1'b1) begin
            got_q.push_back(sh);
        end
    end

    // ==========================================
    // send side: bit 0 of f goes first, line idles high
    task automatic send_frame(input logic [10:0] f, input int n);
        @(posedge pclk);
        for (int i = 0; i < n; i++) begin
            rxd <= f[i];
            repeat (bit_cyc) @(posedge pclk);
        end
        rxd <= 1'b1;
    endtask : send_frame
endmodule : asct_partner

// file: dv/test_asct_top.sv
`timescale 1ns/1ps
`include "asct_defines.svh"

module test_asct_top;
    logic        pclk;
    logic        presetn;
    logic        ce;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rxd;
    logic        cts_n;
    logic        txd;
    logic        tx_oe;
    int          n_mismatch;
    int          cmp_count;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  rb;
    logic [7:0]  exp_q[$];
    logic [31:0] rst_tab[3] = '{32'h0000_0000, 32'h0000_0104, 32'h0000_0020};

    asct_top u_asct_top (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd(rxd), .cts_n(cts_n), .txd(txd), .tx_oe(tx_oe));
    asct_partner u_asct_partner (.pclk(pclk), .txd(txd), .rxd(rxd));

    // ==========================================
    // helpers
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1);
        chk("pready wait", 32'd2, k);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wait_rx(input int n);
        for (int k = 0; k < 4000 && u_asct_partner.got_q.size() < n; k++) @(posedge pclk);
    endtask : wait_rx

    task automatic send_chr(input logic [7:0] c);
        u_asct_partner.send_frame({2'b01, c, 1'b0}, 10);
        repeat (8) @(posedge pclk);
    endtask : send_chr

    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test

    // ==========================================
    // clock and watchdog
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    initial begin
        repeat (80000) @(posedge pclk);
        n_mismatch++;
        finish_test();
    end

    // ==========================================
    // main sequence
    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        cts_n = 1'b1;
        n_mismatch = 0;
        cmp_count = 0;
        void'($urandom(27615));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0000_0000);
            chk("reset value", rst_tab[i], rd);
        end
        apb(1'b0, 12'h0FC, 32'h0000_0000);
        chk("unmapped slverr", 32'h0000_0001, {31'h0, err});
        apb(1'b1, `ASCT_OFF_BAUD, 32'h0000_0010);
        apb(1'b1, `ASCT_OFF_CTRL, 32'h0000_0001);
        // full duplex: both directions at once
        rb = 8'($urandom);
        fork
            for (int i = 0; i < 4; i++) begin
                exp_q.push_back(8'($urandom));
                apb(1'b1, `ASCT_OFF_TXDATA, {24'h0, exp_q[i]});
                wait_rx(i + 1);
            end
            send_chr(rb);
        join
        chk("tx count", exp_q.size(), u_asct_partner.got_q.size());
        foreach (exp_q[i]) chk("tx char", exp_q[i], u_asct_partner.got_q[i]);
        apb(1'b0, `ASCT_OFF_RXDATA, 32'h0000_0000);
        chk("rx char", rb, rd[7:0]);
        // two-wire refuses full duplex
        apb(1'b1, `ASCT_OFF_CTRL, 32'h0000_0005);
        chk("two-wire slverr", 32'h0000_0001, {31'h0, err});
        apb(1'b0, `ASCT_OFF_CTRL, 32'h0000_0000);
        chk("two-wire mode", 32'h0000_0000, rd[1:0]);
        chk("two-wire tx_oe", 32'h0000_0000, {31'h0, tx_oe});
        // even parity: bad then good frame
        apb(1'b1, `ASCT_OFF_CTRL, 32'h0000_0011);
        rb = 8'($urandom);
        u_asct_partner.send_frame({1'b1, ~^rb, rb, 1'b0}, 11);
        repeat (8) @(posedge pclk);
        apb(1'b0, `ASCT_OFF_STATUS, 32'h0000_0000);
        chk("parity flag", 32'h0000_0001, rd[`ASCT_ST_FRMERR]);
        apb(1'b1, `ASCT_OFF_STATUS, 32'h0000_0018);
        u_asct_partner.send_frame({1'b1, ^rb, rb, 1'b0}, 11);
        repeat (8) @(posedge pclk);
        apb(1'b0, `ASCT_OFF_STATUS, 32'h0000_0000);
        chk("parity clear", 32'h0000_0000, rd[`ASCT_ST_FRMERR]);
        chk("cdt quiet", 32'h0000_0000, rd[`ASCT_ST_CDTERR]);
        apb(1'b0, `ASCT_OFF_RXDATA, 32'h0000_0000);
        chk("rx parity char", rb, rd[7:0]);
        // short character delay: the open frame times out
        apb(1'b1, `ASCT_OFF_CDT, 32'h0000_0002);
        repeat (40) @(posedge pclk);
        apb(1'b0, `ASCT_OFF_STATUS, 32'h0000_0000);
        chk("cdt flag", 32'h0000_0001, rd[`ASCT_ST_CDTERR]);
        apb(1'b1, `ASCT_OFF_STATUS, 32'h0000_0008);
        apb(1'b0, `ASCT_OFF_STATUS, 32'h0000_0000);
        chk("cdt cleared", 32'h0000_0000, rd[`ASCT_ST_CDTERR]);
        // printer mode with software flow control
        apb(1'b1, `ASCT_OFF_CTRL, 32'h0000_0082);
        send_chr(8'h41);
        apb(1'b0, `ASCT_OFF_STATUS, 32'h0000_0000);
        chk("printer rx ignored", 32'h0000_0000, rd[`ASCT_ST_RXVALID]);
        send_chr(`ASCT_CHR_XOFF);
        apb(1'b0, `ASCT_OFF_STATUS, 32'h0000_0000);
        chk("xoff flag", 32'h0000_0001, rd[`ASCT_ST_XOFF]);
        apb(1'b1, `ASCT_OFF_TXDATA, 32'h0000_005A);
        repeat (16 * 15) @(posedge pclk);
        chk("held by xoff", 32'd4, u_asct_partner.got_q.size());
        send_chr(`ASCT_CHR_XON);
        wait_rx(5);
        chk("resumed char", 32'h0000_005A, u_asct_partner.got_q[4]);
        // printer busy on cts holds the next character
        cts_n <= 1'b0;
        apb(1'b1, `ASCT_OFF_CTRL, 32'h0000_0182);
        apb(1'b1, `ASCT_OFF_TXDATA, 32'h0000_00A5);
        repeat (16 * 15) @(posedge pclk);
        chk("held by busy", 32'd5, u_asct_partner.got_q.size());
        cts_n <= 1'b1;
        wait_rx(6);
        chk("released char", 32'h0000_00A5, u_asct_partner.got_q[5]);
        finish_test();
    end
endmodule : test_asct_top
